// File: dv/pwc_host_model.sv
// host model issuing configuration and test alias requests
`timescale 1ns/1ps
`default_nettype none
module pwc_host_model (
  // clock
  input  wire logic   clk,
  // configuration requests
  output logic        cfgRead,
  output logic        cfgWrite,
  output logic [7:0]  cfgAddr,
  output logic [3:0]  cfgByteEn,
  output logic [31:0] cfgWData,
  // test alias requests
  output logic        testRead,
  output logic [6:0]  testIndex
);
  // ----------------------------------------
  // request tasks
  // ----------------------------------------
  // one request per call, held across exactly one edge
  task automatic req(input logic rd, input logic wr, input logic tr, input logic [7:0] a,
                     input logic [3:0] be, input logic [31:0] wd, input logic [6:0] ti);
    cfgRead = rd;
    cfgWrite = wr;
    testRead = tr;
    cfgAddr = a;
    cfgByteEn = be;
    cfgWData = wd;
    testIndex = ti;
    @(posedge clk);
    #10;
  endtask
  // released lines flip so a stale value never passes for a real one
  task automatic idle();
    cfgRead = 1'b0;
    cfgWrite = 1'b0;
    testRead = 1'b0;
    cfgAddr = ~cfgAddr;
    cfgByteEn = ~cfgByteEn;
    cfgWData = ~cfgWData;
    testIndex = ~testIndex;
    @(posedge clk);
    #10;
  endtask
  // quiet bus at time zero
  initial begin
    cfgRead = 1'b0;
    cfgWrite = 1'b0;
    testRead = 1'b0;
    cfgAddr = 8'h00;
    cfgByteEn = 4'h0;
    cfgWData = 32'h0;
    testIndex = 7'h00;
  end
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// self-checking bench for the capabilities register
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin nFail++; \
  $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module tb_top;
  logic clk, reset, ce, loadValid, cfgRead, cfgWrite, testRead;
  logic cfgAck, testAck, capsLoaded;
  logic [15:0] loadData, testRData, caps, w;
  logic [7:0]  cfgAddr;
  logic [3:0]  cfgByteEn;
  logic [31:0] cfgWData, cfgRData, e;
  logic [6:0]  testIndex;
  logic [31:0] qc[$];
  logic [15:0] qt[$];
  logic [15:0] tbl[12];
  int nFail, nTests, cycles;

  pwc_capabilities_reg dut_u (.clk(clk), .reset(reset), .ce(ce), .loadValid(loadValid),
    .loadData(loadData), .cfgRead(cfgRead), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr),
    .cfgByteEn(cfgByteEn), .cfgWData(cfgWData), .cfgAck(cfgAck), .cfgRData(cfgRData),
    .testRead(testRead), .testIndex(testIndex), .testAck(testAck),
    .testRData(testRData), .capsLoaded(capsLoaded));
  pwc_host_model host_u (.clk(clk), .cfgRead(cfgRead), .cfgWrite(cfgWrite),
    .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWData(cfgWData),
    .testRead(testRead), .testIndex(testIndex));

  // ----------------------------------------
  // clock and watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // a hung handshake would otherwise run forever
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      nFail++;
      results();
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // mapped dword is {caps, next pointer 00h, id 01h}, disabled lanes zero
  function automatic logic [31:0] expCfg(logic [7:0] a, logic [3:0] be, logic [15:0] c);
    logic [31:0] v;
    v = {c, 8'h00, 8'h01} & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (a[7:2] == 6'h10) ? v : 32'h0;
  endfunction
  task automatic load(input logic [15:0] d);
    loadValid = 1'b1;
    loadData = d;
    caps = d;
    @(posedge clk);
    #10;
    loadValid = 1'b0;
    loadData = ~d;
  endtask
  // read both views at once, noting what each should return
  task automatic rdBoth(input logic [7:0] a, input logic [3:0] be, input logic [6:0] ti);
    qc.push_back(expCfg(a, be, caps));
    qt.push_back((ti == 7'h24) ? caps : 16'h0);
    host_u.req(1'b1, 1'b0, 1'b1, a, be, $urandom, ti);
  endtask

  // ----------------------------------------
  // monitor: oldest note against each answer
  // ----------------------------------------
  always @(posedge clk) begin
    #1;
    if (cfgAck === 1'b1) begin
      e = (qc.size() != 0) ? qc.pop_front() : 32'hdead_beef;
      `CHK(cfgRData, e)
    end
    if (testAck === 1'b1) begin
      w = (qt.size() != 0) ? qt.pop_front() : 16'hdead;
      `CHK(testRData, w)
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {reset, ce, loadValid, loadData, caps} = {1'b1, 1'b1, 1'b0, 16'h0, 16'h0};
    void'($urandom(19));
    repeat (5) @(posedge clk);
    #10;
    reset = 1'b0;
    host_u.idle();
    `CHK(capsLoaded, 1'b0)
    rdBoth(8'h40, 4'hf, 7'h24);
    host_u.idle();
    $display("test reset_view done");
    // single wake bits, both doze bits, version 1.0, then random words
    tbl = '{16'h0800, 16'h1000, 16'h2000, 16'h4000, 16'h8000, 16'h0400, 16'h0200,
            16'h0001, 16'h0, 16'h0, 16'h0, 16'h0};
    for (int i = 8; i < 12; i++) tbl[i] = 16'($urandom);
    foreach (tbl[i]) begin
      load(tbl[i]);
      rdBoth(8'h42, 4'hc, 7'h24);
      rdBoth(8'h43, 4'h3, 7'h24);
      host_u.idle();
    end
    `CHK(capsLoaded, 1'b1)
    $display("test field_table done");
    for (int i = 0; i < 4; i++) begin
      qc.push_back(32'h0);
      host_u.req(1'b0, 1'b1, 1'b0, 8'h42, 4'hf, $urandom, 7'h00);
    end
    rdBoth(8'h40, 4'hf, 7'h24);
    qc.push_back(expCfg(8'h40, 4'hf, caps));
    host_u.req(1'b1, 1'b1, 1'b0, 8'h42, 4'hf, 32'hffff_ffff, 7'h00);
    host_u.idle();
    $display("test write_ignored done");
    rdBoth(8'h44, 4'hf, 7'h25);
    rdBoth(8'h41, 4'h2, 7'h23);
    host_u.idle();
    ce = 1'b0;
    host_u.req(1'b1, 1'b0, 1'b1, 8'h42, 4'hf, 32'h0, 7'h24);
    host_u.idle();
    ce = 1'b1;
    repeat (3) host_u.idle();
    `CHK(qc.size() + qt.size(), 0)
    $display("test unmapped_and_freeze done");
    results();
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
endmodule
`default_nettype wire

// File: logic/pwc_capabilities_reg.sv
// power management capabilities register with config and test alias views
`timescale 1ns/1ps
`default_nettype none
`include "pwc_cfg.svh"
module pwc_capabilities_reg (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  // eeprom loader
  input  wire logic        loadValid,
  input  wire logic [15:0] loadData,
  // host configuration access
  input  wire logic        cfgRead,
  input  wire logic        cfgWrite,
  input  wire logic [7:0]  cfgAddr,
  input  wire logic [3:0]  cfgByteEn,
  input  wire logic [31:0] cfgWData,
  output logic             cfgAck,
  output logic [31:0]      cfgRData,
  // test alias access
  input  wire logic        testRead,
  input  wire logic [6:0]  testIndex,
  output logic             testAck,
  output logic [15:0]      testRData,
  // status
  output logic             capsLoaded
);

  // ----------------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------------
  // true when a byte address falls in the dword holding id, pointer and caps
  function automatic logic isCapDword(input logic [7:0] addr);
    isCapDword = (addr[7:2] == 6'(`PWC_CAP_ID_OFFSET >> 2));
  endfunction

  // ----------------------------------------------------------------------------
  // loaded capabilities
  // ----------------------------------------------------------------------------
  pwc_caps_if capsBus ();

  pwc_eeprom_latch u_latch (
    .clk       (clk),
    .reset     (reset),
    .ce        (ce),
    .loadValid (loadValid),
    .loadData  (loadData),
    .caps      (capsBus.source)
  );

  // ----------------------------------------------------------------------------
  // read data selection
  // ----------------------------------------------------------------------------
  pwc_pkg::pwc_state_t state;
  pwc_pkg::pwc_state_t next_state;
  logic [15:0]         capsWord;
  logic                cfgHit;
  logic                cfgReq;
  logic [31:0]         capDword;
  logic [31:0]         laneMask;
  logic [31:0]         next_cfgRData;
  logic                testHit;
  logic [15:0]         next_testRData;

  // the same word feeds both views, so they cannot disagree
  assign capsWord = capsBus.value;                                    // RULE2
  assign cfgHit   = isCapDword(cfgAddr);
  assign cfgReq   = cfgRead || cfgWrite;
  // writes never touch capsWord; the host just gets its completion
  assign capDword = {capsWord, `PWC_NEXT_PTR_VALUE, `PWC_CAP_ID_VALUE}; // RULE3 RULE5 RULE9

  // only enabled byte lanes carry data, the rest read zero
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_lane
      assign laneMask[lane*8 +: 8] = {8{cfgByteEn[lane]}};
    end
  endgenerate

  // unmapped addresses and writes without a read answer with zero data
  assign next_cfgRData  = (cfgRead && cfgHit) ? (capDword & laneMask) : 32'h0000_0000;
  assign testHit        = (testIndex == `PWC_TEST_ALIAS_INDEX);
  assign next_testRData = testHit ? capsWord : 16'h0000;              // RULE2
  assign next_state     = cfgReq ? pwc_pkg::PWC_ANSWER : pwc_pkg::PWC_IDLE;

  // ----------------------------------------------------------------------------
  // configuration answer
  // ----------------------------------------------------------------------------
  // one-cycle ack per request; a held request simply answers every cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      state    <= pwc_pkg::PWC_IDLE;
      cfgAck   <= 1'b0;
      cfgRData <= 32'h0000_0000;
    end else if (ce) begin
      state    <= next_state;
      cfgAck   <= cfgReq;                                             // RULE10
      cfgRData <= next_cfgRData;
    end
  end

  // ----------------------------------------------------------------------------
  // test alias answer
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      testAck   <= 1'b0;
      testRData <= 16'h0000;
    end else if (ce) begin
      testAck   <= testRead;
      testRData <= testRead ? next_testRData : 16'h0000;
    end
  end

  // ----------------------------------------------------------------------------
  // status
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      capsLoaded <= 1'b0;
    end else if (ce) begin
      capsLoaded <= capsBus.loaded;
    end
  end

  // ----------------------------------------------------------------------------
  // state tracking
  // ----------------------------------------------------------------------------
  // ack and state move together; the case keeps the pair honest
  logic stateMatchesAck;
  always_comb begin
    stateMatchesAck = 1'b0;
    case (state)
      pwc_pkg::PWC_IDLE:   stateMatchesAck = !cfgAck;
      pwc_pkg::PWC_ANSWER: stateMatchesAck = cfgAck;
      default:             stateMatchesAck = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  caps_from_load_a: assert property (@(posedge clk) disable iff (reset)
    ce && loadValid ##1 ce && cfgRead && cfgHit && (&cfgByteEn[3:2])
    |=> cfgRData[31:16] == $past(loadData, 2)) // RULE1
    else $error("config view does not show eeprom word");

  alias_matches_cfg_a: assert property (@(posedge clk) disable iff (reset)
    ce && cfgRead && cfgHit && (&cfgByteEn) && testRead && testHit
    |=> cfgRData[31:16] == testRData) // RULE2
    else $error("test alias differs from config view");

  alias_read_value_a: assert property (@(posedge clk) disable iff (reset)
    ce && testRead && testHit |=> testAck && testRData == $past(capsWord)) // RULE2
    else $error("test alias read wrong");

  wake_field_a: assert property (@(posedge clk) disable iff (reset)
    ce && cfgRead && cfgHit && cfgByteEn[3]
    |=> cfgRData[31:27] == $past(capsBus.value.wakeStateSupport)) // RULE3
    else $error("wake support field misplaced");

  wake_zero_a: assert property (@(posedge clk) disable iff (reset)
    ce && cfgRead && cfgHit && cfgByteEn[3] && !capsWord[`PWC_WAKE_D3COLD_BIT]
    |=> !cfgRData[16 + `PWC_WAKE_D3COLD_BIT]) // RULE4
    else $error("unsupported wake state reads one");

  wake_d0_map_a: assert property (@(posedge clk) disable iff (reset)
    ce && cfgRead && cfgHit && cfgByteEn[3]
    |=> cfgRData[16 + `PWC_WAKE_D0_BIT] == $past(capsBus.value.wakeStateSupport[0])
        && cfgRData[16 + `PWC_WAKE_D3HOT_BIT]
           == $past(capsBus.value.wakeStateSupport[3])) // RULE5
    else $error("wake state bit mapping wrong");

  deep_doze_a: assert property (@(posedge clk) disable iff (reset)
    ce && cfgRead && cfgHit && cfgByteEn[3]
    |=> cfgRData[16 + `PWC_DEEP_DOZE_BIT] == $past(capsBus.value.deepDozeSupported)) // RULE6
    else $error("deep doze bit wrong");

  light_doze_a: assert property (@(posedge clk) disable iff (reset)
    ce && cfgRead && cfgHit && cfgByteEn[3]
    |=> cfgRData[16 + `PWC_LIGHT_DOZE_BIT]
        == $past(capsBus.value.lightDozeSupported)) // RULE7
    else $error("light doze bit wrong");

  version_field_a: assert property (@(posedge clk) disable iff (reset)
    ce && cfgRead && cfgHit && cfgByteEn[2]
    |=> cfgRData[16 + `PWC_VERSION_MSB : 16 + `PWC_VERSION_LSB]
        == $past(capsBus.value.pmInterfaceVersion)) // RULE8
    else $error("interface version field wrong");

  null_pointer_a: assert property (@(posedge clk) disable iff (reset)
    ce && cfgRead && cfgHit && cfgByteEn[1]
    |=> cfgAck && cfgRData[15:8] == `PWC_NEXT_PTR_VALUE
        && cfgRData[7:0] == ($past(cfgByteEn[0]) ? `PWC_CAP_ID_VALUE : 8'h00)) // RULE9
    else $error("capability list bytes wrong");

  write_ignored_a: assert property (@(posedge clk) disable iff (reset)
    ce && cfgWrite && cfgHit && !loadValid
    |=> cfgAck && $stable(capsWord)) // RULE10
    else $error("config write altered capabilities");

  state_ack_pair_a: assert property (@(posedge clk) disable iff (reset)
    stateMatchesAck)
    else $error("state and ack disagree");

endmodule
`default_nettype wire

// File: logic/pwc_eeprom_latch.sv
// holds the capabilities word delivered by the eeprom loader
`timescale 1ns/1ps
`default_nettype none
`include "pwc_cfg.svh"
module pwc_eeprom_latch (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  // eeprom loader side
  input  wire logic        loadValid,
  input  wire logic [15:0] loadData,
  // capabilities out
  pwc_caps_if.source       caps
);

  // ----------------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------------
  // every bit comes from the loader; nothing here is a fixed strap
  always_ff @(posedge clk) begin
    if (reset) begin
      caps.value  <= pwc_pkg::pwc_caps_t'(`PWC_CAPS_RESET);
      caps.loaded <= 1'b0;
    end else if (ce && loadValid) begin
      caps.value  <= pwc_pkg::pwc_caps_t'(loadData); // RULE1 RULE3 RULE4 RULE5 RULE6 RULE7 RULE8
      caps.loaded <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  load_copies_word_a: assert property (@(posedge clk) disable iff (reset)
    ce && loadValid |=> caps.value == $past(loadData) && caps.loaded) // RULE1
    else $error("loaded word not taken from eeprom data");

  holds_without_load_a: assert property (@(posedge clk) disable iff (reset)
    !(ce && loadValid) |=> $stable(caps.value)) // RULE1
    else $error("capabilities changed without a load");

endmodule
`default_nettype wire

// File: pkg/pwc_caps_if.sv
// carrier of the loaded capabilities value between latch and register block
`timescale 1ns/1ps
`default_nettype none
interface pwc_caps_if;
  pwc_pkg::pwc_caps_t value;
  logic               loaded;
  modport source (output value, output loaded);
  modport sink   (input value, input loaded);
endinterface
`default_nettype wire

// File: pkg/pwc_cfg.svh
// constants for the power management capabilities register block
// Summary of operation
// RULE1 - every capabilities bit is taken from the value the EEPROM loader delivers, none is fixed.
// RULE2 - the same capabilities value is also readable at the test alias register index.
// RULE3 - bits 15 to 11 form a five-bit wake state support field, one bit per power state.
// RULE4 - a wake state support bit reads zero when the wake signal cannot be raised from that state.
// RULE5 - bit 11 is D0, bit 12 is D1, bit 13 is D2, bit 14 is D3hot and bit 15 is D3cold.
// RULE6 - bit 10 reads one when the deep doze state (D2) is supported and zero otherwise.
// RULE7 - bit 9 reads one when the light doze state (D1) is supported and zero otherwise.
// RULE8 - bits 2 to 0 give the interface version, where 001b means revision 1.0.
// RULE9 - the next capability pointer byte at offset 41h reads as a null pointer.
// RULE10 - host writes to the capabilities register are ignored.
`ifndef PWC_CFG_SVH
`define PWC_CFG_SVH

// ----------------------------------------------------------------------------
// configuration space layout
// ----------------------------------------------------------------------------
`define PWC_CAP_ID_OFFSET     8'h40
`define PWC_NEXT_PTR_OFFSET   8'h41
`define PWC_CAPS_OFFSET       8'h42
`define PWC_CAP_ID_VALUE      8'h01
`define PWC_NEXT_PTR_VALUE    8'h00
`define PWC_TEST_ALIAS_INDEX  7'h24

// ----------------------------------------------------------------------------
// field positions and values
// ----------------------------------------------------------------------------
`define PWC_WAKE_MSB          15
`define PWC_WAKE_LSB          11
`define PWC_WAKE_D0_BIT       11
`define PWC_WAKE_D1_BIT       12
`define PWC_WAKE_D2_BIT       13
`define PWC_WAKE_D3HOT_BIT    14
`define PWC_WAKE_D3COLD_BIT   15
`define PWC_DEEP_DOZE_BIT     10
`define PWC_LIGHT_DOZE_BIT    9
`define PWC_VERSION_MSB       2
`define PWC_VERSION_LSB       0
`define PWC_VERSION_REV10     3'h1
`define PWC_CAPS_RESET        16'h0000

`endif

// File: pkg/pwc_pkg.sv
// types shared by the power management capabilities block
package pwc_pkg;

  // capabilities word, msb first
  typedef struct packed {
    logic [4:0] wakeStateSupport;   // d3cold, d3hot, d2, d1, d0  RULE3 RULE4 RULE5
    logic       deepDozeSupported;  // RULE6
    logic       lightDozeSupported; // RULE7
    logic [5:0] otherFields;
    logic [2:0] pmInterfaceVersion; // RULE8
  } pwc_caps_t;

  // configuration access state
  typedef enum logic [1:0] {
    PWC_IDLE,
    PWC_ANSWER
  } pwc_state_t;

endpackage
